// *** rtl/rpt_pkg.sv ***
package rpt_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [5:0] RPT_IDX_MODE = 6'h2a;
   localparam logic [5:0] RPT_IDX_PRESC_LO = 6'h2b;
   localparam logic [5:0] RPT_IDX_RELOAD_HI = 6'h2c;
   localparam logic [5:0] RPT_IDX_RELOAD_LO = 6'h2d;
   localparam logic [5:0] RPT_IDX_COUNT_HI = 6'h2e;
   localparam logic [5:0] RPT_IDX_COUNT_LO = 6'h2f;
   localparam logic [5:0] RPT_IDX_CTRL = 6'h30;
   localparam logic [5:0] RPT_IDX_STATUS = 6'h31;
   localparam int RPT_ADDR_W = 8;
   localparam int RPT_DATA_W = 32;
   // Reset values
   localparam logic [7:0] RPT_MODE_RST = 8'h00;
   localparam logic [7:0] RPT_PRESC_LO_RST = 8'h00;
   localparam logic [7:0] RPT_RELOAD_RST = 8'h00;
   localparam logic [7:0] RPT_CTRL_RST = 8'h00;
   localparam logic [15:0] RPT_COUNT_RST = 16'h0000;
   // Mode register fields
   localparam int RPT_MODE_AUTO_BIT = 7;
   localparam int RPT_MODE_GATE_HI = 6;
   localparam int RPT_MODE_GATE_LO = 5;
   localparam int RPT_MODE_RELOAD_BIT = 4;
   localparam int RPT_MODE_PHI_HI = 3;
   // Control register fields
   localparam int RPT_CTRL_EVEN_BIT = 0;
   localparam int RPT_CTRL_RXMULT_BIT = 1;
   localparam int RPT_CTRL_STOP_BIT = 2;
   localparam int RPT_CTRL_START_BIT = 3;
   // Status register fields
   localparam int RPT_STAT_RUN_BIT = 0;
   localparam int RPT_STAT_IRQ_BIT = 1;
   // Received bits (start bit plus four data bits) that end the timer
   localparam logic [2:0] RPT_RX_STOP_BITS = 3'h5;
   typedef enum logic [1:0] {
      RPT_GATE_NONE = 2'b00,
      RPT_GATE_MULTIFUNCTION_INPUT_PIN = 2'b01,
      RPT_GATE_AUX = 2'b10,
      RPT_GATE_UNDEF = 2'b11
   } rpt_gate_t;
endpackage

// *** rtl/rpt_prescaler.sv ***
`timescale 1ns/1ns
`default_nettype none
module rpt_prescaler (
   input wire logic clk_in, // Base clock
   input wire logic rst_n_in, // Synchronised reset, active low
   rpt_tick_if.presc tk // Prescaler controls and tick
);
   import rpt_pkg::*;
   logic [12:0] div_q;
   logic [12:0] last;

   // Period is 2*P+1 base clocks, or 2*P+2 in even mode
   assign last = {prescaler_value_x2(tk.prescaler_value)} +
                 {12'h000, tk.even_division_select};
   assign tk.tick = tk.run && !tk.restart && (div_q == last);

   function automatic logic [12:0] prescaler_value_x2(input logic [11:0] p);
      prescaler_value_x2 = {p, 1'b0};
   endfunction

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= 13'h0000;
      end else if (tk.restart || tk.tick) begin
         div_q <= 13'h0000;
      end else if (tk.run) begin
         div_q <= div_q + 13'h0001;
      end
   end
endmodule // rpt_prescaler
`default_nettype wire

// *** rtl/rpt_tick_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface rpt_tick_if;
   logic [11:0] prescaler_value;
   logic even_division_select;
   logic run;
   logic restart;
   logic tick;
   modport ctrl (output prescaler_value, even_division_select, run, restart, input tick);
   modport presc (input prescaler_value, even_division_select, run, restart, output tick);
endinterface
`default_nettype wire

// *** rtl/rpt_timer.sv ***
//Summary of operation
// - Auto-start bit starts timer at transmit end
// - Without multi-receive, fifth received bit stops timer
// - With multi-receive, received bits never stop timer
// - Auto-start clear: protocol events ignored
// - Gating 00 none, 01 multifunction, 10 auxiliary
// - Gated mode: running flag follows gate enable
// - Auto-reload restarts countdown from reload value
// - No auto-reload: count to zero, raise flag
// - Prescaler high nibble from mode bits 3:0
// - Prescaler low byte from prescaler register
// - Odd mode divides by twice prescaler plus one
// - Even mode divides by twice prescaler plus two
// - Sixteen-bit reload in two bytes, loaded at start
// - Reload writes wait for next start event or auto-reload
// - Live count readable as two bytes
// - Count bytes read-only at 2Eh and 2Fh
// - Mode register at 2Ah, reset 00h, field layout
`timescale 1ns/1ns
`default_nettype none
module rpt_timer (
   input wire logic ref_clk_in, // 100 MHz clock
   input wire logic rst_n_in, // Asynchronous reset, active low
   input wire logic [rpt_pkg::RPT_ADDR_W-1:0] avs_address_in, // Byte address
   input wire logic avs_read_in, // Read request
   input wire logic avs_write_in, // Write request
   input wire logic [rpt_pkg::RPT_DATA_W-1:0] avs_writedata_in, // Write data
   input wire logic [3:0] avs_byteenable_in, // Byte enables
   output logic [rpt_pkg::RPT_DATA_W-1:0] avs_readdata_out, // Read data
   output logic avs_waitrequest_out, // Wait request
   input wire logic tx_end_in, // Pulse: transmission finished
   input wire logic rx_bit_in, // Pulse: one bit received
   input wire logic multifunction_input_pin_in, // Gate source 01
   input wire logic first_auxiliary_pin_in, // Gate source 10
   output logic timer_running_flag_out, // Timer running
   output logic timer_expired_irq_flag_out // Sticky expiry flag
);
   import rpt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset synchroniser
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle per access
   logic ack_q;
   logic [RPT_DATA_W-1:0] rdata_q;
   logic [5:0] idx;
   logic idx_ok;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] rbyte;

   assign idx = avs_address_in[7:2];
   assign idx_ok = (avs_address_in[1:0] == 2'b00);
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
   assign wr_en = avs_write_in && ack_q && idx_ok && avs_byteenable_in[0];
   assign wbyte = avs_writedata_in[7:0];
   assign avs_readdata_out = rdata_q;

   always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read_in || avs_write_in) && !ack_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers
   logic [7:0] mode_q;
   logic [7:0] presc_lo_q;
   logic [7:0] reload_hi_q;
   logic [7:0] reload_lo_q;
   logic [7:0] ctrl_q;
   logic stop_req;
   logic sw_start;

   always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         mode_q <= RPT_MODE_RST;
         presc_lo_q <= RPT_PRESC_LO_RST;
         reload_hi_q <= RPT_RELOAD_RST;
         reload_lo_q <= RPT_RELOAD_RST;
         ctrl_q <= RPT_CTRL_RST;
      end else if (wr_en) begin
         case (idx)
            RPT_IDX_MODE: mode_q <= wbyte;
            RPT_IDX_PRESC_LO: presc_lo_q <= wbyte;
            RPT_IDX_RELOAD_HI: reload_hi_q <= wbyte;
            RPT_IDX_RELOAD_LO: reload_lo_q <= wbyte;
            RPT_IDX_CTRL: ctrl_q <= {6'h00, wbyte[RPT_CTRL_RXMULT_BIT],
                                     wbyte[RPT_CTRL_EVEN_BIT]};
            default: ;
         endcase
      end
   end

   // Stop and start are self-clearing strobes
   assign stop_req = wr_en && (idx == RPT_IDX_CTRL) && wbyte[RPT_CTRL_STOP_BIT];
   assign sw_start = wr_en && (idx == RPT_IDX_CTRL) && wbyte[RPT_CTRL_START_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode and gating
   logic auto_start_on_tx_end;
   logic auto_reload_enable;
   rpt_gate_t gating_select;
   logic gate_open;
   logic receive_multiple_frames;

   assign auto_start_on_tx_end = mode_q[RPT_MODE_AUTO_BIT];
   assign auto_reload_enable = mode_q[RPT_MODE_RELOAD_BIT];
   assign gating_select = rpt_gate_t'(mode_q[RPT_MODE_GATE_HI:RPT_MODE_GATE_LO]);
   assign receive_multiple_frames = ctrl_q[RPT_CTRL_RXMULT_BIT];

   always_comb begin
      case (gating_select)
         RPT_GATE_NONE: gate_open = 1'b1;
         RPT_GATE_MULTIFUNCTION_INPUT_PIN: gate_open = multifunction_input_pin_in;
         RPT_GATE_AUX: gate_open = first_auxiliary_pin_in;
         default: gate_open = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler
   rpt_tick_if tk ();
   logic running_q;
   logic start_evt;

   assign tk.prescaler_value = {mode_q[RPT_MODE_PHI_HI:0], presc_lo_q};
   assign tk.even_division_select = ctrl_q[RPT_CTRL_EVEN_BIT];
   assign tk.run = running_q && gate_open;
   assign tk.restart = start_evt;

   rpt_prescaler u_presc (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_sync_q),
      .tk(tk.presc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Start and stop events
   logic [2:0] rx_bits_q;
   logic rx_stop;

   assign start_evt = sw_start || (auto_start_on_tx_end && tx_end_in);
   assign rx_stop = auto_start_on_tx_end && !receive_multiple_frames && rx_bit_in &&
                    (rx_bits_q == (RPT_RX_STOP_BITS - 3'h1));

   always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rx_bits_q <= 3'h0;
      end else if (start_evt) begin
         rx_bits_q <= 3'h0;
      end else if (running_q && rx_bit_in && rx_bits_q != RPT_RX_STOP_BITS) begin
         rx_bits_q <= rx_bits_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter
   logic [15:0] count_q;
   logic [15:0] reload_val;
   logic expire;
   logic irq_q;
   logic irq_clr;

   assign reload_val = {reload_hi_q, reload_lo_q};
   assign expire = tk.tick && (count_q == 16'h0000);

   always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         count_q <= RPT_COUNT_RST;
      end else if (start_evt) begin
         count_q <= reload_val;
      end else if (expire && auto_reload_enable) begin
         count_q <= reload_val;
      end else if (tk.tick && count_q != 16'h0000) begin
         count_q <= count_q - 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         running_q <= 1'b0;
      end else if (start_evt) begin
         running_q <= 1'b1;
      end else if (stop_req || rx_stop) begin
         running_q <= 1'b0;
      end else if (expire && !auto_reload_enable) begin
         running_q <= 1'b0;
      end
   end

   // Write one to clear; a new expiry in the same cycle wins
   assign irq_clr = wr_en && (idx == RPT_IDX_STATUS) && wbyte[RPT_STAT_IRQ_BIT];
   always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         irq_q <= 1'b0;
      end else if (expire && !auto_reload_enable) begin
         irq_q <= 1'b1;
      end else if (irq_clr) begin
         irq_q <= 1'b0;
      end
   end

   assign timer_running_flag_out = running_q && gate_open;
   assign timer_expired_irq_flag_out = irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      case (idx)
         RPT_IDX_MODE: rbyte = mode_q;
         RPT_IDX_PRESC_LO: rbyte = presc_lo_q;
         RPT_IDX_RELOAD_HI: rbyte = reload_hi_q;
         RPT_IDX_RELOAD_LO: rbyte = reload_lo_q;
         RPT_IDX_COUNT_HI: rbyte = count_q[15:8];
         RPT_IDX_COUNT_LO: rbyte = count_q[7:0];
         RPT_IDX_CTRL: rbyte = ctrl_q;
         RPT_IDX_STATUS: rbyte = {6'h00, irq_q, timer_running_flag_out};
         default: rbyte = 8'h00;
      endcase
      if (!idx_ok) begin
         rbyte = 8'h00;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= '0;
      end else if (avs_read_in && !ack_q) begin
         rdata_q <= {24'h000000, rbyte};
      end
   end
endmodule // rpt_timer
`default_nettype wire

// *** tb/rpt_timer_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module rpt_timer_chk (
   input wire logic ref_clk_in, // Clock
   input wire logic rst_n_in, // Reset
   input wire logic [rpt_pkg::RPT_ADDR_W-1:0] avs_address_in, // Address
   input wire logic avs_read_in, // Read
   input wire logic avs_write_in, // Write
   input wire logic [rpt_pkg::RPT_DATA_W-1:0] avs_writedata_in, // Data
   input wire logic [3:0] avs_byteenable_in, // Enables
   input wire logic [rpt_pkg::RPT_DATA_W-1:0] avs_readdata_out, // Read data
   input wire logic avs_waitrequest_out, // Stall
   input wire logic tx_end_in, // Tx end
   input wire logic rx_bit_in, // Rx bit
   input wire logic multifunction_input_pin_in, // Gate 01
   input wire logic first_auxiliary_pin_in, // Gate 10
   input wire logic timer_running_flag_out, // Running
   input wire logic timer_expired_irq_flag_out // Expired
);
   import rpt_pkg::*;
   logic [7:0] mode_q;
   logic mode_wr;
   // Shadow of the mode register, updated on the accepting edge only
   assign mode_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
      && avs_address_in == {RPT_IDX_MODE, 2'b00};
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_q <= RPT_MODE_RST;
      end else if (mode_wr) begin
         mode_q <= avs_writedata_in[7:0];
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("bus access not answered");
   bus_idle_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
      else $error("stall without access");
   auto_start_a: assert property (
      tx_end_in && mode_q[7] && mode_q[6:5] == 2'b00 && !avs_write_in
      |=> timer_running_flag_out) else $error("no start at tx end");
   no_auto_start_a: assert property (
      !mode_q[7] && mode_q[6:5] == 2'b00 && !avs_write_in && !timer_running_flag_out
      |=> !timer_running_flag_out) else $error("start without auto bit");
   gate_multifunction_input_pin_a: assert property (
      mode_q[6:5] == 2'b01 && !multifunction_input_pin_in |-> !timer_running_flag_out)
      else $error("runs with pin gate shut");
   gate_aux_a: assert property (
      mode_q[6:5] == 2'b10 && !first_auxiliary_pin_in |-> !timer_running_flag_out)
      else $error("runs with aux gate shut");
   gate_undef_a: assert property (mode_q[6:5] == 2'b11 |-> !timer_running_flag_out)
      else $error("runs with gate code 11");
   irq_cause_a: assert property ($rose(timer_expired_irq_flag_out)
      |-> !$past(mode_q[4]) && $past(timer_running_flag_out)) else $error("bad expiry flag");
   irq_hold_a: assert property (timer_expired_irq_flag_out
      && !avs_write_in |=> timer_expired_irq_flag_out) else $error("flag dropped");
   cover property ($rose(timer_expired_irq_flag_out));
   cover property (rx_bit_in ##1 $fell(timer_running_flag_out));
   cover property (avs_read_in && !avs_waitrequest_out && avs_readdata_out[0]);
endmodule // rpt_timer_chk
`default_nettype wire

// *** tb/rpt_timer_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module rpt_timer_tb_top;
   import rpt_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [RPT_ADDR_W-1:0] avs_address_in = 8'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [RPT_DATA_W-1:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'h0;
   logic [RPT_DATA_W-1:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic tx_end_in = 1'b0;
   logic rx_bit_in = 1'b0;
   logic multifunction_input_pin_in = 1'b0;
   logic first_auxiliary_pin_in = 1'b0;
   logic timer_running_flag_out;
   logic timer_expired_irq_flag_out;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int seed = 32'hcb13;
   int n;
   logic [31:0] rd_q;
   logic [11:0] ph;
   logic [15:0] rl;
   logic ev;
   int mdl_reg [64];
   rpt_timer u_dut (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .tx_end_in(tx_end_in),
      .rx_bit_in(rx_bit_in),
      .multifunction_input_pin_in(multifunction_input_pin_in),
      .first_auxiliary_pin_in(first_auxiliary_pin_in),
      .timer_running_flag_out(timer_running_flag_out),
      .timer_expired_irq_flag_out(timer_expired_irq_flag_out)
   );
   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("CHECK FAILED t=%0t timeout", $time);
         end_of_test();
      end
   end
   ////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
      logic [31:0] r;
      @(posedge ref_clk_in);
      r = $random(seed);
      avs_address_in <= {i, 2'b00};
      avs_writedata_in <= {r[31:8], d};
      avs_byteenable_in <= {r[3:1], 1'b1};
      avs_write_in <= w;
      avs_read_in <= !w;
      // Waitrequest and read data are taken at the same rising edge
      do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
      rd_q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      bus(1'b1, i, d);
      // Model: setting bytes keep what was written, control keeps its two setting bits
      if (i == RPT_IDX_CTRL) begin
         mdl_reg[i] = int'(d & 8'h03);
      end else if (i inside {RPT_IDX_MODE, RPT_IDX_PRESC_LO, RPT_IDX_RELOAD_HI,
            RPT_IDX_RELOAD_LO}) begin
         mdl_reg[i] = int'(d);
      end
   endtask
   task automatic rd(input logic [5:0] i, input logic [7:0] e, input string m);
      bus(1'b0, i, 8'h00);
      ck(rd_q, {24'h0, e}, m);
   endtask
   task automatic fl(input logic er, input logic ei, input string m);
      @(negedge ref_clk_in);
      ck({timer_running_flag_out, timer_expired_irq_flag_out}, {er, ei}, m);
   endtask
   // Start edge is the second rising edge inside this task
   task automatic evt(input logic rx);
      @(posedge ref_clk_in);
      rx_bit_in <= rx;
      tx_end_in <= !rx;
      @(posedge ref_clk_in);
      rx_bit_in <= 1'b0;
      tx_end_in <= 1'b0;
   endtask
   task automatic pins(input logic mf, input logic ax);
      @(posedge ref_clk_in);
      multifunction_input_pin_in <= mf;
      first_auxiliary_pin_in <= ax;
   endtask
   task automatic cfg(input logic [7:0] md, input logic [7:0] pl, input logic [7:0] ct,
         input logic [15:0] r);
      wr(RPT_IDX_CTRL, ct);
      wr(RPT_IDX_PRESC_LO, pl);
      wr(RPT_IDX_RELOAD_HI, r[15:8]);
      wr(RPT_IDX_RELOAD_LO, r[7:0]);
      wr(RPT_IDX_MODE, md);
      wr(RPT_IDX_STATUS, 8'h02);
      rd(RPT_IDX_MODE, md, "mode rw");
      rd(RPT_IDX_PRESC_LO, pl, "presc rw");
      rd(RPT_IDX_RELOAD_HI, 8'(mdl_reg[RPT_IDX_RELOAD_HI]), "reload hi model");
      rd(RPT_IDX_RELOAD_LO, 8'(mdl_reg[RPT_IDX_RELOAD_LO]), "reload lo model");
      rd(RPT_IDX_CTRL, 8'(mdl_reg[RPT_IDX_CTRL]), "ctrl model");
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      rd(RPT_IDX_MODE, 8'h00, "mode reset");
      rd(RPT_IDX_RELOAD_HI, 8'h00, "reload hi reset");
      rd(RPT_IDX_RELOAD_LO, 8'h00, "reload lo reset");
      rd(6'h3f, 8'h00, "unmapped");
      $display("test reset done");
      // Expiry time follows (reload + 1) tick periods of 2P+1 or 2P+2 clocks
      for (int k = 0; k < 3; k++) begin
         ph = (k == 2) ? 12'h100 : 12'h002;
         ev = (k == 1);
         rl = (k == 2) ? 16'h0001 : 16'h0003;
         cfg({4'h8, ph[11:8]}, ph[7:0], {7'h00, ev}, rl);
         evt(1'b0);
         n = 0;
         do begin @(negedge ref_clk_in); n++; end while (timer_expired_irq_flag_out !== 1'b1);
         ck(n, (rl + 1) * (2 * ph + 1 + ev) + 1, "expiry time");
         fl(1'b0, 1'b1, "expired");
         rd(RPT_IDX_COUNT_HI, 8'h00, "count hi");
         wr(RPT_IDX_COUNT_LO, 8'h5a);
         rd(RPT_IDX_COUNT_LO, 8'h00, "count read only");
      end
      wr(RPT_IDX_STATUS, 8'h02);
      fl(1'b0, 1'b0, "flag cleared");
      $display("test expiry done");
      cfg(8'h90, 8'h20, 8'h00, 16'h0002);
      evt(1'b0);
      repeat (250) @(posedge ref_clk_in);
      fl(1'b1, 1'b0, "auto reload");
      wr(RPT_IDX_RELOAD_HI, 8'h40);
      rd(RPT_IDX_COUNT_HI, 8'h00, "reload deferred");
      wr(RPT_IDX_CTRL, 8'h08);
      rd(RPT_IDX_COUNT_HI, 8'h40, "reload at start");
      rd(RPT_IDX_STATUS, 8'h01, "status running");
      wr(RPT_IDX_CTRL, 8'h04);
      fl(1'b0, 1'b0, "stop request");
      $display("test reload done");
      for (int m = 0; m < 2; m++) begin
         cfg(8'h80, 8'h20, {6'h00, m[0], 1'b0}, 16'h0100);
         evt(1'b0);
         repeat (4) evt(1'b1);
         fl(1'b1, 1'b0, "four rx bits");
         evt(1'b1);
         fl(m[0], 1'b0, "fifth rx bit");
         wr(RPT_IDX_CTRL, 8'h06);
         fl(1'b0, 1'b0, "stop request");
      end
      cfg(8'h00, 8'h02, 8'h00, 16'h0010);
      evt(1'b0);
      fl(1'b0, 1'b0, "no auto start");
      $display("test protocol done");
      for (int g = 1; g < 4; g++) begin
         pins(1'b0, 1'b0);
         cfg({1'b1, g[1:0], 5'h00}, 8'h20, 8'h00, 16'h0100);
         evt(1'b0);
         repeat (200) @(posedge ref_clk_in);
         fl(1'b0, 1'b0, "gate shut");
         rd(RPT_IDX_COUNT_HI, 8'h01, "gated hold hi");
         rd(RPT_IDX_COUNT_LO, 8'h00, "gated hold lo");
         pins(g == 1, g == 2);
         fl(g != 3, 1'b0, "gate open");
      end
      $display("test gating done");
      end_of_test();
   end
endmodule // rpt_timer_tb_top
bind rpt_timer rpt_timer_chk u_chk (
   .ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in),
   .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .tx_end_in(tx_end_in),
   .rx_bit_in(rx_bit_in),
   .multifunction_input_pin_in(multifunction_input_pin_in),
   .first_auxiliary_pin_in(first_auxiliary_pin_in),
   .timer_running_flag_out(timer_running_flag_out),
   .timer_expired_irq_flag_out(timer_expired_irq_flag_out)
);
`default_nettype wire
